// ### sim/clock_source.sv
// reference and pll clock sources driving the clock output block
module clock_source
(
    output logic REF_CLOCK_IN,
    output logic PLL_CLOCK_IN
);
    timeunit 1ns;
    timeprecision 1ps;
    // edges kept off both clock edges so sampling never races
    initial
    begin
        REF_CLOCK_IN = 1'b0;
        PLL_CLOCK_IN = 1'b0;
        #3;
        fork
            forever #40 REF_CLOCK_IN = ~REF_CLOCK_IN;
            forever #30 PLL_CLOCK_IN = ~PLL_CLOCK_IN;
        join
    end
endmodule

// ### sim/core_clock_gen_test.sv
// self-checking bench for the core clock output block
module core_clock_gen_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic SYS_CLK = 1'b0, RESETN = 1'b0, PLL_INIT_SELECT = 1'b1, REF_CLOCK_IN, PLL_CLOCK_IN, oc;
    logic [7:0] MUL_FACTOR = 8'h01, DIV_FACTOR = 8'h01;
    logic CORE_CLOCK_OUT, CRYSTAL_DRIVE_OUT, PLL_ENABLE_BIT, NMI_REQUEST;
    logic [3:0] rh;
    logic [2:0] ph;
    int bad_count = 0, checked = 0, pulses;
    clock_source src_u (.REF_CLOCK_IN(REF_CLOCK_IN), .PLL_CLOCK_IN(PLL_CLOCK_IN));
    core_clock_gen dut_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .REF_CLOCK_IN(REF_CLOCK_IN),
        .PLL_INIT_SELECT(PLL_INIT_SELECT), .PLL_CLOCK_IN(PLL_CLOCK_IN), .MUL_FACTOR(MUL_FACTOR),
        .DIV_FACTOR(DIV_FACTOR), .CORE_CLOCK_OUT(CORE_CLOCK_OUT), .CRYSTAL_DRIVE_OUT(CRYSTAL_DRIVE_OUT),
        .PLL_ENABLE_BIT(PLL_ENABLE_BIT), .NMI_REQUEST(NMI_REQUEST));
    initial forever #5 SYS_CLK = ~SYS_CLK;
    task automatic chk(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    // strap held long in reset; glitch drops the shared pin mid-reset
    task automatic reboot(input logic strap, input logic glitch);
        RESETN = 1'b0;
        PLL_INIT_SELECT = strap;
        repeat (2) @(negedge SYS_CLK);
        PLL_INIT_SELECT = strap & ~glitch;
        repeat (2) @(negedge SYS_CLK);
        PLL_INIT_SELECT = strap;
        repeat (3) @(negedge SYS_CLK);
        RESETN = 1'b1;
        @(negedge SYS_CLK);
        chk("pll_enable", strap, PLL_ENABLE_BIT);
        PLL_INIT_SELECT = 1'b1;
    endtask
    // copies seen two negedges after the source; half rate one later, as it passes the toggle flop
    task automatic watch(input int mode);
        pulses = 0;
        for (int i = 0; i < 200; i++)
        begin
            @(negedge SYS_CLK);
            if (i > 3 && mode == 0)
                chk("half_rate", rh[2] & ~rh[3], CORE_CLOCK_OUT ^ oc);
            if (i > 3 && mode != 0)
                chk("core_out", mode == 1 ? rh[1] : ph[1], CORE_CLOCK_OUT);
            if (i > 3)
                chk("crystal", ~rh[1], CRYSTAL_DRIVE_OUT);
            pulses += int'(NMI_REQUEST === 1'b1);
            rh = {rh[2:0], REF_CLOCK_IN};
            ph = {ph[1:0], PLL_CLOCK_IN};
            oc = CORE_CLOCK_OUT;
        end
    endtask
    task automatic results;
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(negedge SYS_CLK);
        reboot(1'b0, 1'b0);
        watch(0);
        reboot(1'b1, 1'b1);
        watch(1);
        chk("nmi_in_reset", 1'b1, pulses == 0);
        PLL_INIT_SELECT = 1'b0;
        watch(1);
        chk("nmi_pulses", 1'b1, pulses == 1);
        MUL_FACTOR = 8'h02;
        watch(2);
        MUL_FACTOR = 8'h01;
        DIV_FACTOR = 8'h02;
        watch(2);
        results();
    end
endmodule

// ### verilog/clk_out_pkg.sv
// package of constants for the core clock output and shared nmi pin
// Overview of operation
// - clock output follows internal core clock phase
// - pll at unity ratios: output tracks reference
// - pll off: output is half reference rate
// - during reset, init pin loads pll enable
// - after reset, falling pin edge requests nmi
package clk_out_pkg;
    localparam logic PLL_ENABLE_RESET = 1'b0;
    localparam logic NMI_IDLE_LEVEL = 1'b1;
    localparam logic [7:0] FACTOR_ONE = 8'h01;
    localparam int SYNC_STAGES = 2;
endpackage

// ### verilog/core_clock_gen.sv
// core clock output generator, pll enable capture and nmi edge detector
module core_clock_gen
#(
    parameter int FACTOR_W = 8
)
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic REF_CLOCK_IN,
    input wire logic PLL_INIT_SELECT,
    input wire logic PLL_CLOCK_IN,
    input wire logic [FACTOR_W-1:0] MUL_FACTOR,
    input wire logic [FACTOR_W-1:0] DIV_FACTOR,
    output logic CORE_CLOCK_OUT,
    output logic CRYSTAL_DRIVE_OUT,
    output logic PLL_ENABLE_BIT,
    output logic NMI_REQUEST
);
    // ****************************************************
    // pin synchronisers
    // ****************************************************
    localparam int PIN_COUNT = 3;

    logic ref_sync;
    logic pin_sync_lvl;
    logic pll_sync;
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_clean;

    assign pin_raw = {PLL_CLOCK_IN, PLL_INIT_SELECT, REF_CLOCK_IN};

    generate
        for (genvar g = 0; g < PIN_COUNT; g++)
        begin : g_sync
            pin_sync u_sync
            (
                .clk(SYS_CLK),
                .resetn(RESETN),
                .async_in(pin_raw[g]),
                .sync_out(pin_clean[g])
            );
        end
    endgenerate

    assign ref_sync = pin_clean[0];
    assign pin_sync_lvl = pin_clean[1];
    assign pll_sync = pin_clean[2];

    // ****************************************************
    // strap synchroniser
    // ****************************************************
    // never reset: a reset chain would show the idle level and hide the strap
    logic strap_meta;
    logic strap_sync;

    always_ff @(posedge SYS_CLK)
    begin
        strap_meta <= PLL_INIT_SELECT;
        strap_sync <= strap_meta;
    end

    // ****************************************************
    // pll enable capture
    // ****************************************************
    // captured by a clocked process, never as a reset value, so the strap stays legal
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            PLL_ENABLE_BIT <= strap_sync;
        end
    end

    // ****************************************************
    // ratio decode
    // ****************************************************
    // unity decode, shared by the output mux and its checks
    function automatic logic is_unity(input logic [FACTOR_W-1:0] mul,
                                      input logic [FACTOR_W-1:0] div);
        return (mul == FACTOR_W'(clk_out_pkg::FACTOR_ONE)) &&
               (div == FACTOR_W'(clk_out_pkg::FACTOR_ONE));
    endfunction

    // ****************************************************
    // clock output selection
    // ****************************************************
    logic ref_prev;
    logic half_clk;
    logic core_clk;
    wire ref_rise = ref_sync & ~ref_prev;
    wire unity = is_unity(MUL_FACTOR, DIV_FACTOR);
    // unity ratio: pll clock equals reference, so reference phase is used directly
    wire next_core = PLL_ENABLE_BIT ? (unity ? ref_sync : pll_sync) : half_clk;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            // follows ref_sync, held high in reset, so release never shows a false rise
            ref_prev <= ref_sync;
            half_clk <= 1'b0;
            core_clk <= 1'b0;
            CORE_CLOCK_OUT <= 1'b0;
            CRYSTAL_DRIVE_OUT <= 1'b1;
        end
        else
        begin
            ref_prev <= ref_sync;
            if (ref_rise)
                half_clk <= ~half_clk;
            core_clk <= next_core;
            CORE_CLOCK_OUT <= next_core;
            CRYSTAL_DRIVE_OUT <= ~ref_sync;
        end
    end

    // ****************************************************
    // nmi falling edge detector
    // ****************************************************
    // sampled on core clock rising edges; limitation: pulses shorter than a core period may be missed
    logic core_prev;
    logic nmi_prev;
    wire core_rise = core_clk & ~core_prev;
    wire nmi_fall = core_rise & nmi_prev & ~pin_sync_lvl;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            core_prev <= 1'b0;
            nmi_prev <= clk_out_pkg::NMI_IDLE_LEVEL;
            NMI_REQUEST <= 1'b0;
        end
        else
        begin
            core_prev <= core_clk;
            if (core_rise)
                nmi_prev <= pin_sync_lvl;
            NMI_REQUEST <= nmi_fall;
        end
    end

    // ****************************************************
    // checks: output phase
    // ****************************************************
    a_out_core_phase: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        CORE_CLOCK_OUT == core_clk) else $error("output off core phase");

    a_ratio_follows_pll: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (PLL_ENABLE_BIT && !unity) |=> (CORE_CLOCK_OUT == $past(pll_sync))) else $error("ratio not pll");

    // ****************************************************
    // checks: unity ratio
    // ****************************************************
    a_unity_follows_ref: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (PLL_ENABLE_BIT && unity) |=> (CORE_CLOCK_OUT == $past(ref_sync))) else $error("unity not ref");

    // ****************************************************
    // checks: half rate
    // ****************************************************
    a_half_rate_toggle: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        ref_rise |=> (half_clk != $past(half_clk))) else $error("half rate did not toggle");

    a_half_rate_hold: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !ref_rise |=> (half_clk == $past(half_clk))) else $error("half rate toggled without edge");

    a_ref_rise_single: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        ref_rise |=> !ref_rise) else $error("reference rise seen twice");

    a_pll_off_out: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        !PLL_ENABLE_BIT |=> (CORE_CLOCK_OUT == $past(half_clk))) else $error("pll off output wrong");

    // ****************************************************
    // checks: enable strap
    // ****************************************************
    a_enable_held: assert property (@(posedge SYS_CLK)
        RESETN && $past(RESETN) |-> $stable(PLL_ENABLE_BIT)) else $error("enable changed out of reset");

    a_enable_capture: assert property (@(posedge SYS_CLK)
        $rose(RESETN) |-> (PLL_ENABLE_BIT == $past(strap_sync))) else $error("enable not captured");

    // ****************************************************
    // checks: nmi request
    // ****************************************************
    a_nmi_on_fall: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        nmi_fall |=> NMI_REQUEST) else $error("nmi missed");

    a_nmi_pulse: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        NMI_REQUEST |=> !NMI_REQUEST) else $error("nmi longer than a cycle");

    a_nmi_needs_fall: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        NMI_REQUEST |-> $past(nmi_fall)) else $error("nmi without falling edge");

    // ****************************************************
    // checks: nmi during reset
    // ****************************************************
    a_nmi_quiet_reset: assert property (@(posedge SYS_CLK)
        !RESETN |=> !NMI_REQUEST) else $error("nmi after reset");

    a_detector_idle: assert property (@(posedge SYS_CLK)
        $rose(RESETN) |-> nmi_prev) else $error("detector not idle at release");
endmodule

// ### verilog/pin_sync.sv
// two-flop synchroniser for one asynchronous pin
module pin_sync
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    // stage1 feeds only the second flop; metastability stays contained
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            stage1 <= clk_out_pkg::NMI_IDLE_LEVEL;
            sync_out <= clk_out_pkg::NMI_IDLE_LEVEL;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
